// File: rtl/sdct_pkg.sv
// Function
// - Device accepts write latency 1 to 7
// - Latency 1-3: receivers on at activate
// - Latency 4-7: receivers on at write
// - Latency above 4 needs latency*period over 7ns
// - No strobe rise in half cycle before preamble
// - Controller drives final postamble strobe rise
// - First strobe edge at write latency
// - Refresh to activate/refresh: 39 cycles
// - Activate to read: 10 cycles
// - Activate to write: 6 cycles
// - Activate to activate: 8 cycles
// - Last write beat to precharge: 9 cycles
// - Auto precharge starts 7 after last beat
// - Last write beat to read: 5 cycles
// - Mode load to any command: 6 cycles
// - Last auto-precharge write beat to activate: 18 cycles
// - Self refresh exit to read: 20000 cycles
// - All rows refreshed every 32 ms
// - Refresh and mode load only when idle
package sdct_pkg;
	typedef enum logic [3:0] {
		CMD_NOP, CMD_MODE, CMD_ACT, CMD_READ, CMD_WRITE,
		CMD_PRE, CMD_REFRESH, CMD_SREF_ENTER, CMD_SREF_EXIT
	} sdct_cmd_t;

	localparam int BANKS     = 4;
	localparam int BANK_W    = 2;
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int WL_W      = 3;
	localparam int AP_BIT    = 8;
	localparam int BEATS     = 2;
	localparam int GAP_W     = 8;
	localparam int SR_W      = 16;
	localparam int CNT_W     = 4;

	localparam logic [2:0] WL_MIN       = 3'h1;
	localparam logic [2:0] WL_EARLY_MAX = 3'h3;
	localparam logic [2:0] WL_CK_FREE   = 3'h4;
	localparam logic [2:0] WL_RESET     = 3'h5;
	localparam int WL_CK_LIMIT_PS       = 7000;

	localparam int CLK_PERIOD_NS  = 25;
	localparam int LINK_DIV       = 8;
	localparam int LINK_HALF      = LINK_DIV / 2;
	localparam int LINK_PERIOD_NS = CLK_PERIOD_NS * LINK_DIV;
	localparam int LINK_PERIOD_PS = LINK_PERIOD_NS * 1000;

	localparam int REFRESH_GAP      = 39;
	localparam int ACT_RD_GAP       = 10;
	localparam int ACT_WR_GAP       = 6;
	localparam int ACT_ACT_GAP      = 8;
	localparam int WR_PRE_GAP       = 9;
	localparam int AP_WR_RECOVERY   = 7;
	localparam int WR_RD_GAP        = 5;
	localparam int MODE_GAP         = 6;
	localparam int AP_TOTAL_GAP     = 18;
	localparam int SELFREF_EXIT_GAP = 20000;

	localparam int REFRESH_WINDOW_NS = 32_000_000;
	localparam int ROWS              = 4096;
	localparam int REFRESH_EVERY     = REFRESH_WINDOW_NS / ROWS / LINK_PERIOD_NS;
endpackage

// File: rtl/sdct_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdct_link_if;
	logic                               link_clk;
	sdct_pkg::sdct_cmd_t                cmd;
	logic [sdct_pkg::BANK_W-1:0]        bank;
	logic [sdct_pkg::ADDR_W-1:0]        addr;
	logic [sdct_pkg::DATA_W-1:0]        dq_o;
	logic                               dq_oe;
	logic                               strobe_o;
	logic                               strobe_oe;
	logic [sdct_pkg::DATA_W-1:0]        dq;
	logic                               write_strobe;

	// Termination pulls released lines high
	assign dq = dq_oe ? dq_o : '1;
	assign write_strobe = strobe_oe ? strobe_o : 1'b1;

	modport ctrl (output link_clk, cmd, bank, addr, dq_o, dq_oe, strobe_o, strobe_oe);
	modport mem (input link_clk, cmd, bank, addr, dq, write_strobe);
endinterface
`default_nettype wire

// File: rtl/sdct_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sdct_mem (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic                          ce,
	sdct_link_if.mem                           link,
	output logic [sdct_pkg::WL_W-1:0]          write_latency,
	output logic                               input_buffer_on,
	output logic                               wr_valid,
	output logic [sdct_pkg::BANK_W-1:0]        wr_bank,
	output logic [sdct_pkg::ADDR_W-1:0]        wr_col,
	output logic [sdct_pkg::DATA_W-1:0]        wr_data,
	output logic [sdct_pkg::BANKS-1:0]         bank_open,
	output logic [sdct_pkg::BANKS-1:0]         ap_start,
	output logic                               in_selfrefresh
);
	localparam int LW = 1 + 4 + sdct_pkg::BANK_W + sdct_pkg::ADDR_W + sdct_pkg::DATA_W;
	localparam int CW = sdct_pkg::CNT_W;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [LW-1:0]  s1_reg;
	logic [LW-1:0]  s2_reg;
	logic           lclk_d3_reg;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			lclk_d3_reg <= 1'b0;
		end
		else if (ce)
		begin
			s1_reg <= {link.link_clk, link.cmd, link.bank, link.addr, link.dq};
			s2_reg <= s1_reg;
			lclk_d3_reg <= s2_reg[LW-1];
		end
	end

	logic                               rise;
	sdct_pkg::sdct_cmd_t                c_cmd;
	logic [sdct_pkg::BANK_W-1:0]        c_bank;
	logic [sdct_pkg::ADDR_W-1:0]        c_addr;
	logic [sdct_pkg::DATA_W-1:0]        c_dq;

	assign rise = s2_reg[LW-1] & ~lclk_d3_reg;
	assign c_cmd = sdct_pkg::sdct_cmd_t'(s2_reg[LW-2 -: 4]);
	assign {c_bank, c_addr, c_dq} = s2_reg[LW-6:0];

	// ************************************************************
	// Command decode and write capture
	// ************************************************************
	logic [2:0]                   wl_reg, wl_next;
	logic                         buf_reg, buf_next;
	logic [3:0]                   open_reg, open_next;
	logic [3:0]                   aps_reg, aps_next;
	logic [CW-1:0]                ap_reg [4];
	logic [CW-1:0]                ap_next [4];
	logic                         sref_reg, sref_next;
	logic                         w_on_reg, w_on_next;
	logic [CW-1:0]                w_cnt_reg, w_cnt_next;
	logic [2:0]                   w_wl_reg, w_wl_next;
	logic                         w_ap_reg, w_ap_next;
	logic                         vld_reg, vld_next;
	logic [1:0]                   bank_reg, bank_next;
	logic [11:0]                  col_reg, col_next;
	logic [31:0]                  data_reg, data_next;

	always_comb
	begin
		wl_next = wl_reg;
		buf_next = buf_reg;
		open_next = open_reg;
		aps_next = '0;
		ap_next = ap_reg;
		sref_next = sref_reg;
		w_on_next = w_on_reg;
		w_cnt_next = w_cnt_reg;
		w_wl_next = w_wl_reg;
		w_ap_next = w_ap_reg;
		vld_next = 1'b0;
		bank_next = bank_reg;
		col_next = col_reg;
		data_next = data_reg;
		if (rise)
		begin
			for (int b = 0; b < sdct_pkg::BANKS; b++)
			begin
				if (ap_reg[b] != '0)
				begin
					ap_next[b] = ap_reg[b] - 1'b1;
					if (ap_reg[b] == CW'(1))
					begin
						aps_next[b] = 1'b1;
						open_next[b] = 1'b0;
					end
				end
			end
			if (w_on_reg)
			begin
				w_cnt_next = w_cnt_reg + 1'b1;
				if (w_cnt_reg == {1'b0, w_wl_reg} || w_cnt_reg == {1'b0, w_wl_reg} + 1'b1)
				begin
					vld_next = 1'b1;
					data_next = c_dq;
				end
				if (w_cnt_reg == {1'b0, w_wl_reg} + 1'b1)
				begin
					w_on_next = 1'b0;
					if (w_ap_reg)
						ap_next[bank_reg] = CW'(sdct_pkg::AP_WR_RECOVERY);
					if (w_wl_reg > sdct_pkg::WL_EARLY_MAX)
						buf_next = 1'b0;
				end
			end
			unique case (c_cmd)
				sdct_pkg::CMD_MODE:
					if (c_addr[2:0] >= sdct_pkg::WL_MIN)
						wl_next = c_addr[2:0];
				sdct_pkg::CMD_ACT:
				begin
					open_next[c_bank] = 1'b1;
					if (wl_reg <= sdct_pkg::WL_EARLY_MAX)
						buf_next = 1'b1;
				end
				sdct_pkg::CMD_WRITE:
				begin
					w_on_next = 1'b1;
					w_cnt_next = CW'(1);
					w_wl_next = wl_reg;
					w_ap_next = c_addr[sdct_pkg::AP_BIT];
					bank_next = c_bank;
					col_next = c_addr;
					buf_next = 1'b1;
				end
				sdct_pkg::CMD_PRE:
				begin
					open_next[c_bank] = 1'b0;
					if ((open_reg & ~(4'h1 << c_bank)) == '0)
						buf_next = 1'b0;
				end
				sdct_pkg::CMD_SREF_ENTER:
					sref_next = 1'b1;
				sdct_pkg::CMD_SREF_EXIT:
					sref_next = 1'b0;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wl_reg <= sdct_pkg::WL_RESET;
			buf_reg <= 1'b0;
			open_reg <= '0;
			aps_reg <= '0;
			ap_reg <= '{default: '0};
			sref_reg <= 1'b0;
			w_on_reg <= 1'b0;
			w_cnt_reg <= '0;
			w_wl_reg <= '0;
			w_ap_reg <= 1'b0;
			vld_reg <= 1'b0;
			bank_reg <= '0;
			col_reg <= '0;
			data_reg <= '0;
		end
		else if (ce)
		begin
			wl_reg <= wl_next;
			buf_reg <= buf_next;
			open_reg <= open_next;
			aps_reg <= aps_next;
			ap_reg <= ap_next;
			sref_reg <= sref_next;
			w_on_reg <= w_on_next;
			w_cnt_reg <= w_cnt_next;
			w_wl_reg <= w_wl_next;
			w_ap_reg <= w_ap_next;
			vld_reg <= vld_next;
			bank_reg <= bank_next;
			col_reg <= col_next;
			data_reg <= data_next;
		end
	end

	assign write_latency = wl_reg;
	assign input_buffer_on = buf_reg;
	assign wr_valid = vld_reg;
	assign wr_bank = bank_reg;
	assign wr_col = col_reg;
	assign wr_data = data_reg;
	assign bank_open = open_reg;
	assign ap_start = aps_reg;
	assign in_selfrefresh = sref_reg;
endmodule
`default_nettype wire

// File: rtl/sdct_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sdct_ctrl #(
	parameter int SELFREF_EXIT_CYCLES = sdct_pkg::SELFREF_EXIT_GAP
)(
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic                          ce,
	input  wire logic                          req_valid,
	input  wire sdct_pkg::sdct_cmd_t           req_cmd,
	input  wire logic [sdct_pkg::BANK_W-1:0]   req_bank,
	input  wire logic [sdct_pkg::ADDR_W-1:0]   req_addr,
	input  wire logic [63:0]                   req_wdata,
	output logic                               req_ack,
	output logic                               req_refused,
	output logic                               refresh_due,
	output logic [sdct_pkg::WL_W-1:0]          write_latency,
	sdct_link_if.ctrl                          link
);
	localparam int GW = sdct_pkg::GAP_W;
	localparam int SW = sdct_pkg::SR_W;
	localparam int CW = sdct_pkg::CNT_W;

	// ************************************************************
	// Link clock divider
	// ************************************************************
	logic [2:0]  div_reg, div_next;
	logic        lclk_reg, lclk_next;
	logic        tick;

	always_comb
	begin
		div_next = div_reg + 1'b1;
		lclk_next = div_next < 3'(sdct_pkg::LINK_HALF);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			div_reg <= '0;
			lclk_reg <= 1'b1;
		end
		else if (ce)
		begin
			div_reg <= div_next;
			lclk_reg <= lclk_next;
		end
	end

	// Pins change on the falling link edge, mid-way between sampling edges
	assign tick = ce && div_reg == 3'(sdct_pkg::LINK_HALF - 1);

	// ************************************************************
	// Command gate, gap counters and write strobe
	// ************************************************************
	logic [3:0]         open_reg, open_next;
	logic [GW-1:0]      rd_gap_reg [4];
	logic [GW-1:0]      rd_gap_next [4];
	logic [GW-1:0]      wr_gap_reg [4];
	logic [GW-1:0]      wr_gap_next [4];
	logic [GW-1:0]      pre_gap_reg [4];
	logic [GW-1:0]      pre_gap_next [4];
	logic [GW-1:0]      dal_reg [4];
	logic [GW-1:0]      dal_next [4];
	logic [GW-1:0]      act_gap_reg, act_gap_next;
	logic [GW-1:0]      ref_gap_reg, ref_gap_next;
	logic [GW-1:0]      mode_gap_reg, mode_gap_next;
	logic [GW-1:0]      wr_rd_reg, wr_rd_next;
	logic [GW-1:0]      ref_tmr_reg, ref_tmr_next;
	logic [SW-1:0]      sr_gap_reg, sr_gap_next;
	logic               sref_reg, sref_next;
	logic               due_reg, due_next;
	logic [2:0]         wl_reg, wl_next;
	logic               ws_on_reg, ws_on_next;
	logic [CW-1:0]      ws_cnt_reg, ws_cnt_next;
	logic [63:0]        wdata_reg, wdata_next;
	logic               ack_reg, ack_next;
	logic               rej_reg, rej_next;
	sdct_pkg::sdct_cmd_t cmd_reg, cmd_next;
	logic [1:0]         bank_reg, bank_next;
	logic [11:0]        addr_reg, addr_next;
	logic [31:0]        dq_reg, dq_next;
	logic               dq_oe_reg, dq_oe_next;
	logic               str_reg, str_next;
	logic               str_oe_reg, str_oe_next;

	logic               all_idle;
	logic               legal;
	logic               wl_ok;
	logic               issue;
	logic               wr_issue;
	logic [CW-1:0]      k;
	logic [CW-1:0]      wl4;

	always_comb
	begin
		all_idle = 1'b1;
		for (int b = 0; b < sdct_pkg::BANKS; b++)
			if (open_reg[b] || dal_reg[b] != '0)
				all_idle = 1'b0;
		// Latency above the free limit only when latency times period clears it
		wl_ok = req_addr[2:0] >= sdct_pkg::WL_MIN
			&& (req_addr[2:0] <= sdct_pkg::WL_CK_FREE
			|| int'(req_addr[2:0]) * sdct_pkg::LINK_PERIOD_PS > sdct_pkg::WL_CK_LIMIT_PS);
		legal = 1'b0;
		if (sref_reg)
			legal = req_cmd == sdct_pkg::CMD_SREF_EXIT;
		else if (mode_gap_reg == '0)
			unique case (req_cmd)
				sdct_pkg::CMD_NOP:
					legal = 1'b1;
				sdct_pkg::CMD_MODE:
					legal = all_idle && !ws_on_reg && wl_ok;
				sdct_pkg::CMD_ACT:
					legal = !open_reg[req_bank] && act_gap_reg == '0
						&& ref_gap_reg == '0 && dal_reg[req_bank] == '0;
				sdct_pkg::CMD_READ:
					legal = open_reg[req_bank] && rd_gap_reg[req_bank] == '0
						&& wr_rd_reg == '0 && sr_gap_reg == '0 && !ws_on_reg;
				sdct_pkg::CMD_WRITE:
					legal = open_reg[req_bank] && wr_gap_reg[req_bank] == '0
						&& !ws_on_reg;
				sdct_pkg::CMD_PRE:
					legal = open_reg[req_bank] && pre_gap_reg[req_bank] == '0;
				sdct_pkg::CMD_REFRESH:
					legal = all_idle && ref_gap_reg == '0;
				sdct_pkg::CMD_SREF_ENTER:
					legal = all_idle && ref_gap_reg == '0;
				default:
					legal = 1'b0;
			endcase
		issue = tick && req_valid && legal;
		wr_issue = issue && req_cmd == sdct_pkg::CMD_WRITE;
		wl4 = {1'b0, wl_reg};

		open_next = open_reg;
		act_gap_next = act_gap_reg;
		ref_gap_next = ref_gap_reg;
		mode_gap_next = mode_gap_reg;
		wr_rd_next = wr_rd_reg;
		sr_gap_next = sr_gap_reg;
		ref_tmr_next = ref_tmr_reg;
		due_next = due_reg;
		sref_next = sref_reg;
		wl_next = wl_reg;
		wdata_next = wdata_reg;
		rd_gap_next = rd_gap_reg;
		wr_gap_next = wr_gap_reg;
		pre_gap_next = pre_gap_reg;
		dal_next = dal_reg;
		ack_next = issue;
		rej_next = tick && req_valid && !legal;
		if (tick)
		begin
			for (int b = 0; b < sdct_pkg::BANKS; b++)
			begin
				if (rd_gap_reg[b] != '0)
					rd_gap_next[b] = rd_gap_reg[b] - 1'b1;
				if (wr_gap_reg[b] != '0)
					wr_gap_next[b] = wr_gap_reg[b] - 1'b1;
				if (pre_gap_reg[b] != '0)
					pre_gap_next[b] = pre_gap_reg[b] - 1'b1;
				if (dal_reg[b] != '0)
					dal_next[b] = dal_reg[b] - 1'b1;
			end
			if (act_gap_reg != '0)
				act_gap_next = act_gap_reg - 1'b1;
			if (ref_gap_reg != '0)
				ref_gap_next = ref_gap_reg - 1'b1;
			if (mode_gap_reg != '0)
				mode_gap_next = mode_gap_reg - 1'b1;
			if (wr_rd_reg != '0)
				wr_rd_next = wr_rd_reg - 1'b1;
			if (sr_gap_reg != '0)
				sr_gap_next = sr_gap_reg - 1'b1;
			ref_tmr_next = ref_tmr_reg - 1'b1;
			if (ref_tmr_reg == '0)
			begin
				ref_tmr_next = GW'(sdct_pkg::REFRESH_EVERY - 1);
				due_next = 1'b1;
			end
		end
		if (issue)
			unique case (req_cmd)
				sdct_pkg::CMD_MODE:
				begin
					wl_next = req_addr[2:0];
					mode_gap_next = GW'(sdct_pkg::MODE_GAP - 1);
				end
				sdct_pkg::CMD_ACT:
				begin
					open_next[req_bank] = 1'b1;
					act_gap_next = GW'(sdct_pkg::ACT_ACT_GAP - 1);
					rd_gap_next[req_bank] = GW'(sdct_pkg::ACT_RD_GAP - 1);
					wr_gap_next[req_bank] = GW'(sdct_pkg::ACT_WR_GAP - 1);
				end
				sdct_pkg::CMD_WRITE:
				begin
					wdata_next = req_wdata;
					wr_rd_next = GW'(int'(wl_reg) + sdct_pkg::BEATS + sdct_pkg::WR_RD_GAP - 2);
					pre_gap_next[req_bank] =
						GW'(int'(wl_reg) + sdct_pkg::BEATS + sdct_pkg::WR_PRE_GAP - 2);
					if (req_addr[sdct_pkg::AP_BIT])
					begin
						open_next[req_bank] = 1'b0;
						dal_next[req_bank] =
							GW'(int'(wl_reg) + sdct_pkg::BEATS + sdct_pkg::AP_TOTAL_GAP - 2);
					end
				end
				sdct_pkg::CMD_PRE:
					open_next[req_bank] = 1'b0;
				sdct_pkg::CMD_REFRESH:
				begin
					ref_gap_next = GW'(sdct_pkg::REFRESH_GAP - 1);
					due_next = tick && ref_tmr_reg == '0; // Set wins
				end
				sdct_pkg::CMD_SREF_ENTER:
					sref_next = 1'b1;
				sdct_pkg::CMD_SREF_EXIT:
				begin
					sref_next = 1'b0;
					sr_gap_next = SW'(SELFREF_EXIT_CYCLES - 1);
				end
				default:
				begin
				end
			endcase
	end

	// Strobe and data slots counted from the write slot
	always_comb
	begin
		k = wr_issue ? '0 : ws_cnt_reg;
		ws_on_next = ws_on_reg;
		ws_cnt_next = ws_cnt_reg;
		cmd_next = cmd_reg;
		bank_next = bank_reg;
		addr_next = addr_reg;
		dq_next = dq_reg;
		dq_oe_next = dq_oe_reg;
		str_next = str_reg;
		str_oe_next = str_oe_reg;
		if (tick)
		begin
			cmd_next = issue ? req_cmd : sdct_pkg::CMD_NOP;
			bank_next = req_bank;
			addr_next = req_addr;
			dq_oe_next = 1'b0;
			str_oe_next = 1'b0;
			str_next = 1'b1;
			if (wr_issue || ws_on_reg)
			begin
				ws_on_next = 1'b1;
				ws_cnt_next = k + 1'b1;
				// Driving low from the released high: no rise ahead of preamble
				if (k == wl4 - 1'b1)
				begin
					str_oe_next = 1'b1;
					str_next = 1'b0;
				end
				else if (k == wl4)
				begin
					str_oe_next = 1'b1;
					dq_oe_next = 1'b1;
					dq_next = wdata_reg[31:0];
				end
				else if (k == wl4 + 1'b1)
				begin
					str_oe_next = 1'b1;
					str_next = 1'b0;
					dq_oe_next = 1'b1;
					dq_next = wdata_reg[63:32];
				end
				else if (k == wl4 + 2'd2)
				begin
					// Termination alone may not make the last rise
					str_oe_next = 1'b1;
					ws_on_next = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			open_reg <= '0;
			rd_gap_reg <= '{default: '0};
			wr_gap_reg <= '{default: '0};
			pre_gap_reg <= '{default: '0};
			dal_reg <= '{default: '0};
			act_gap_reg <= '0;
			ref_gap_reg <= '0;
			mode_gap_reg <= '0;
			wr_rd_reg <= '0;
			ref_tmr_reg <= GW'(sdct_pkg::REFRESH_EVERY - 1);
			sr_gap_reg <= '0;
			sref_reg <= 1'b0;
			due_reg <= 1'b0;
			wl_reg <= sdct_pkg::WL_RESET;
			ws_on_reg <= 1'b0;
			ws_cnt_reg <= '0;
			wdata_reg <= '0;
			ack_reg <= 1'b0;
			rej_reg <= 1'b0;
			cmd_reg <= sdct_pkg::CMD_NOP;
			bank_reg <= '0;
			addr_reg <= '0;
			dq_reg <= '0;
			dq_oe_reg <= 1'b0;
			str_reg <= 1'b1;
			str_oe_reg <= 1'b0;
		end
		else if (ce)
		begin
			open_reg <= open_next;
			rd_gap_reg <= rd_gap_next;
			wr_gap_reg <= wr_gap_next;
			pre_gap_reg <= pre_gap_next;
			dal_reg <= dal_next;
			act_gap_reg <= act_gap_next;
			ref_gap_reg <= ref_gap_next;
			mode_gap_reg <= mode_gap_next;
			wr_rd_reg <= wr_rd_next;
			ref_tmr_reg <= ref_tmr_next;
			sr_gap_reg <= sr_gap_next;
			sref_reg <= sref_next;
			due_reg <= due_next;
			wl_reg <= wl_next;
			ws_on_reg <= ws_on_next;
			ws_cnt_reg <= ws_cnt_next;
			wdata_reg <= wdata_next;
			ack_reg <= ack_next;
			rej_reg <= rej_next;
			cmd_reg <= cmd_next;
			bank_reg <= bank_next;
			addr_reg <= addr_next;
			dq_reg <= dq_next;
			dq_oe_reg <= dq_oe_next;
			str_reg <= str_next;
			str_oe_reg <= str_oe_next;
		end
	end

	assign req_ack = ack_reg;
	assign req_refused = rej_reg;
	assign refresh_due = due_reg;
	assign write_latency = wl_reg;
	assign link.link_clk = lclk_reg;
	assign link.cmd = cmd_reg;
	assign link.bank = bank_reg;
	assign link.addr = addr_reg;
	assign link.dq_o = dq_reg;
	assign link.dq_oe = dq_oe_reg;
	assign link.strobe_o = str_reg;
	assign link.strobe_oe = str_oe_reg;
endmodule
`default_nettype wire

// File: verification/sdct_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Link command and strobe timing checks
// ****************
module sdct_link_monitor (
	input wire logic		clk,
	input wire logic		reset_n,
	input wire logic		link_clk,
	input wire sdct_pkg::sdct_cmd_t	cmd,
	input wire logic [1:0]		bank,
	input wire logic [11:0]		addr,
	input wire logic		dq_oe,
	input wire logic		strobe_o,
	input wire logic		strobe_oe
);
	logic			lclk_q;
	logic			go;
	logic [2:0]		wl;
	logic [15:0]		act_any;
	logic [15:0]		ref_age;
	logic [15:0]		mode_age;
	logic [15:0]		wr_age;
	logic [15:0]		act_age [4];

	// Ages saturate so an old command never looks recent
	function automatic logic [15:0] age(input logic [15:0] a, input logic hit);
		return hit ? 16'h0000 : a + 16'(a != 16'hFFFF);
	endfunction

	// New slot where the link clock falls, so repeats of one command count too
	assign go = lclk_q && !link_clk && cmd != sdct_pkg::CMD_NOP;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lclk_q <= 1'b1;
			wl <= sdct_pkg::WL_RESET;
			act_any <= 16'hFFFF;
			ref_age <= 16'hFFFF;
			mode_age <= 16'hFFFF;
			wr_age <= 16'hFFFF;
			for (int i = 0; i < 4; i++)
				act_age[i] <= 16'hFFFF;
		end
		else
		begin
			lclk_q <= link_clk;
			act_any <= age(act_any, go && cmd == sdct_pkg::CMD_ACT);
			ref_age <= age(ref_age, go && cmd == sdct_pkg::CMD_REFRESH);
			mode_age <= age(mode_age, go && cmd == sdct_pkg::CMD_MODE);
			wr_age <= age(wr_age, go && cmd == sdct_pkg::CMD_WRITE);
			for (int i = 0; i < 4; i++)
				act_age[i] <= age(act_age[i], go && cmd == sdct_pkg::CMD_ACT && bank == 2'(i));
			if (go && cmd == sdct_pkg::CMD_MODE && addr[2:0] != 3'h0)
				wl <= addr[2:0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_CMD_HOLD: assert property (go |=> $stable(cmd)[*7])
		else $error("command slot shorter than a link period");
	AST_MODE_GAP: assert property (go |-> mode_age >= 16'd47)
		else $error("command too soon after mode load");
	AST_ACT_ACT: assert property (go && cmd == sdct_pkg::CMD_ACT |-> act_any >= 16'd63)
		else $error("activates too close");
	AST_ACT_RD: assert property (go && cmd == sdct_pkg::CMD_READ |-> act_age[bank] >= 16'd79)
		else $error("read too soon after activate");
	AST_ACT_WR: assert property (go && cmd == sdct_pkg::CMD_WRITE |-> act_age[bank] >= 16'd47)
		else $error("write too soon after activate");
	AST_REF_GAP: assert property (go && cmd inside {sdct_pkg::CMD_ACT, sdct_pkg::CMD_REFRESH}
		|-> ref_age >= 16'd311)
		else $error("command too soon after refresh");
	AST_PREAMBLE: assert property ($rose(strobe_oe) |-> !strobe_o)
		else $error("strobe rose before preamble");
	AST_POSTAMBLE: assert property ($fell(dq_oe) |-> strobe_oe && strobe_o ##8 !strobe_oe)
		else $error("final strobe rise not driven");
	AST_FIRST_STROBE: assert property ($rose(dq_oe) |-> strobe_o
		&& wr_age + 16'd2 - {wl, 3'h0} <= 16'd2)
		else $error("first strobe edge off write latency");
	AST_BEATS: assert property ($rose(dq_oe) |-> dq_oe[*8] ##1 dq_oe[*8] ##1 !dq_oe)
		else $error("write data not two beats");

	cover property (go && cmd == sdct_pkg::CMD_WRITE);
	cover property (go && cmd == sdct_pkg::CMD_REFRESH);
	cover property (go && cmd == sdct_pkg::CMD_MODE);
endmodule
`default_nettype wire

// File: verification/tb_sdram_command_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_timing;
	// ****************
	// Bench state
	// ****************
	logic			clk = 1'b0;
	logic			reset_n = 1'b0;
	logic			ce = 1'b1;
	logic			req_valid = 1'b0;
	sdct_pkg::sdct_cmd_t	req_cmd = sdct_pkg::CMD_NOP;
	logic [1:0]		req_bank = 2'h0;
	logic [11:0]		req_addr = 12'h000;
	logic [63:0]		req_wdata = 64'h0000_0000_0000_0000;
	logic			req_ack, req_refused, refresh_due, wr_valid, ibuf, sref;
	logic [2:0]		wl_c, wl_m;
	logic [1:0]		wr_bank;
	logic [11:0]		wr_col;
	logic [31:0]		wr_data;
	logic [3:0]		bank_open, ap_start;
	int			n_mismatch = 0, samples_checked = 0;
	int			slot = 0, cyc = 0, t_beat = 0, n_rej = 0, s, s0, s1, sw;
	logic			ibuf_q = 1'b0;
	logic [45:0]		exp_q [$];

	sdct_link_if link ();
	sdct_ctrl #(.SELFREF_EXIT_CYCLES(50)) i_sdct_ctrl (.clk(clk), .reset_n(reset_n),
		.ce(ce), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ack(req_ack),
		.req_refused(req_refused), .refresh_due(refresh_due), .write_latency(wl_c),
		.link(link));
	sdct_mem i_sdct_mem (.clk(clk), .reset_n(reset_n), .ce(ce), .link(link),
		.write_latency(wl_m), .input_buffer_on(ibuf), .wr_valid(wr_valid),
		.wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data), .bank_open(bank_open),
		.ap_start(ap_start), .in_selfrefresh(sref));
	sdct_link_monitor i_sdct_link_monitor (.clk(clk), .reset_n(reset_n),
		.link_clk(link.link_clk),
		.cmd(link.cmd), .bank(link.bank), .addr(link.addr), .dq_oe(link.dq_oe),
		.strobe_o(link.strobe_o), .strobe_oe(link.strobe_oe));

	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge link.link_clk) slot <= slot + 1;
	// Buffer state as it stood when the beat was taken
	always @(posedge clk) ibuf_q <= ibuf;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Held until accepted, so refused slots measure the gap
	task automatic issue(input sdct_pkg::sdct_cmd_t c, input logic [1:0] b,
		input logic [11:0] a, output int sl);
		logic [63:0] d;
		int k;
		d = {$urandom, $urandom};
		@(posedge clk);
		req_cmd <= c;
		req_bank <= b;
		req_addr <= a;
		req_wdata <= d;
		req_valid <= 1'b1;
		for (k = 0; k < 4000 && req_ack !== 1'b1; k++)
		begin
			n_rej += int'(req_refused === 1'b1);
			@(posedge clk);
		end
		req_valid <= 1'b0;
		sl = slot;
		if (k == 4000)
		begin
			n_mismatch++;
			final_report();
		end
		if (c == sdct_pkg::CMD_WRITE)
		begin
			exp_q.push_back({b, a, d[31:0]});
			exp_q.push_back({b, a, d[63:32]});
		end
	endtask

	// ****************
	// Write data scoreboard
	// ****************
	always @(posedge clk)
		if (wr_valid === 1'b1)
		begin
			check({wr_bank, wr_col, wr_data},
				exp_q.size() > 0 ? exp_q.pop_front() : 46'h0);
			check(ibuf_q, 1'b1);
			t_beat = cyc;
		end
		else if (ap_start !== 4'h0)
			check(cyc - t_beat, 56);

	initial
	begin
		void'($urandom(32'ha8a1_8293));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check(wl_c, 3'h5);
		check(wl_m, 3'h5);
		issue(sdct_pkg::CMD_MODE, 2'h0, 12'h002, s0);
		issue(sdct_pkg::CMD_ACT, 2'h0, 12'($urandom), s);
		check(s - s0, 6);
		check(n_rej, 5);
		s0 = s;
		issue(sdct_pkg::CMD_ACT, 2'h1, 12'($urandom), s1);
		check(s1 - s0, 8);
		check(ibuf, 1'b1);
		check({wl_c, wl_m}, 6'h12);
		issue(sdct_pkg::CMD_WRITE, 2'h0, {4'h0, 8'($urandom)}, sw);
		check(sw - s1, 1);
		issue(sdct_pkg::CMD_READ, 2'h0, 12'h000, s);
		check(s - sw, 2 + 1 + 5);
		issue(sdct_pkg::CMD_READ, 2'h1, 12'h000, s);
		check(s - s1, 10);
		issue(sdct_pkg::CMD_PRE, 2'h0, 12'h000, s);
		check(s - sw, 2 + 1 + 9);
		issue(sdct_pkg::CMD_PRE, 2'h1, 12'h000, s);
		issue(sdct_pkg::CMD_MODE, 2'h0, 12'h005, s);
		issue(sdct_pkg::CMD_ACT, 2'h2, 12'($urandom), s0);
		repeat (16) @(posedge clk);
		check(ibuf, 1'b0);
		check(bank_open, 4'h4);
		issue(sdct_pkg::CMD_WRITE, 2'h2, {4'h1, 8'($urandom)}, sw);
		check(sw - s0, 6);
		issue(sdct_pkg::CMD_ACT, 2'h2, 12'($urandom), s);
		check(s - sw, 5 + 1 + 18);
		issue(sdct_pkg::CMD_PRE, 2'h2, 12'h000, s);
		check(refresh_due, 1'b1);
		issue(sdct_pkg::CMD_REFRESH, 2'h0, 12'h000, s0);
		issue(sdct_pkg::CMD_ACT, 2'h3, 12'($urandom), s);
		check(s - s0, 39);
		issue(sdct_pkg::CMD_PRE, 2'h3, 12'h000, s);
		issue(sdct_pkg::CMD_SREF_ENTER, 2'h0, 12'h000, s);
		repeat (16) @(posedge clk);
		check({sref, bank_open}, 5'h10);
		// Clock enable low: the link clock and every gap counter stand still
		ce <= 1'b0;
		@(posedge clk);
		s = slot;
		repeat (24) @(posedge clk);
		check(slot - s, 0);
		ce <= 1'b1;
		issue(sdct_pkg::CMD_SREF_EXIT, 2'h0, 12'h000, s0);
		issue(sdct_pkg::CMD_ACT, 2'h0, 12'($urandom), s);
		issue(sdct_pkg::CMD_READ, 2'h0, 12'h000, s);
		check(s - s0, 50);
		repeat (64) @(posedge clk);
		check(exp_q.size(), 0);
		final_report();
	end
endmodule
`default_nettype wire
